// File: src/scp_pkg.sv
// Summary of operation
// - Scale picks where the count window starts.
// - Scale zero shows the low counter bits.
// - Scale fifteen divides the window rate by 32768.
// - Counter steps by one when enabled.
// - Continuous enable counts every cycle.
// - One-shot enable clears itself at period end.
// - Reset clears both counting enables.
// - Zero-on-match clears counter one cycle later.
// - Window at or above compare zero ends period.
// - Without zero-on-match the counter wraps naturally.
// - Comparator high when window at or above value.
// - Every comparator is evaluated each cycle.
// - Scaled count register shows the selected window.
// - Sticky blocks clearing a set pending bit.
// - Deglitch holds a high result for the period.
// - Four compare registers at consecutive words.
// - Center mode compares inverted window past midpoint.
// - Gang raises pin, next comparator drops it.
// - Deglitched pending can clear only at period start or on a configuration write.
package scp_pkg;

  // Channel count is fixed by the configuration word layout.
  localparam int NCMP = 4;
  localparam int CMP_W_DEF = 16;
  localparam int COUNT_EXTRA = 15;
  localparam int SCALE_W = 4;

  // Register byte offsets.
  localparam logic [5:0] OFS_CFG = 6'h00;
  localparam logic [5:0] OFS_COUNT = 6'h08;
  localparam logic [5:0] OFS_SCALED = 6'h10;
  localparam logic [5:0] OFS_CMP0 = 6'h20;
  localparam logic [5:0] OFS_CMP1 = 6'h24;
  localparam logic [5:0] OFS_CMP2 = 6'h28;
  localparam logic [5:0] OFS_CMP3 = 6'h2C;

  // Field positions within the configuration word.
  localparam int POS_SCALE = 0;
  localparam int POS_STICKY = 8;
  localparam int POS_ZERO = 9;
  localparam int POS_DEGLITCH = 10;
  localparam int POS_EN_ALWAYS = 12;
  localparam int POS_EN_ONESHOT = 13;
  localparam int POS_CENTER = 16;
  localparam int POS_GANG = 24;
  localparam int POS_PEND = 28;

  // Reset value of every register and answer to unmapped reads.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

endpackage

// File: src/scp_compare.sv
`timescale 1ns/1ps
// One comparator, optionally folding the window for center alignment.
module scp_compare
  import scp_pkg::*;
#(
  parameter int CMP_W = CMP_W_DEF
)
(
  // Inputs.
  input wire logic [CMP_W-1:0] scaled,
  input wire logic [CMP_W-1:0] value,
  input wire logic center,
  // Result.
  output logic ge
);

  logic [CMP_W-1:0] eff;

  // Folding past the midpoint gives a symmetric ramp up and down.
  always_comb
  begin
    eff = (center && scaled[CMP_W-1]) ? ~scaled : scaled;
    ge = (eff >= value);
  end

endmodule

// File: src/scp_pending.sv
`timescale 1ns/1ps
// Next value of one pending bit.
module scp_pending
  import scp_pkg::*;
(
  // Inputs.
  input wire logic ge,
  input wire logic pend,
  input wire logic sticky,
  input wire logic deglitch,
  input wire logic period_end,
  input wire logic wr,
  input wire logic wbit,
  // Result.
  output logic pend_next
);

  logic hold;
  logic keep;

  // A live compare always sets the bit, so a set beats a clear.
  always_comb
  begin
    hold = sticky | (deglitch & ~period_end);
    keep = wr ? (wbit | (sticky & pend)) : (pend & hold);
    pend_next = ge | keep;
  end

endmodule

// File: src/scp_core.sv
`timescale 1ns/1ps
// Scaled counter PWM core with four comparators.
module scp_core
  import scp_pkg::*;
#(
  parameter int CMP_W = CMP_W_DEF
)
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RSTN,
  // Register port.
  input wire logic [5:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  // Comparator results.
  output logic [NCMP-1:0] COMPARE_PENDING,
  output logic [NCMP-1:0] WAVEFORM_PIN_OUT
);

  localparam int CW = CMP_W + COUNT_EXTRA;

  // The counter must fit a 32-bit register word.
  generate
    if (CMP_W < 2 || CMP_W > 16)
    begin : g_bad_width
      $error("scp_core: CMP_W must be 2 to 16");
    end
  endgenerate

  typedef struct packed {
    logic [SCALE_W-1:0] scale;
    logic sticky;
    logic zero_cmp;
    logic deglitch;
    logic en_always;
    logic en_oneshot;
    logic [NCMP-1:0] center;
    logic [NCMP-1:0] gang;
    logic [NCMP-1:0] pend;
    logic [NCMP-1:0] pin;
    logic [CW-1:0] count;
    logic [NCMP-1:0][CMP_W-1:0] cmp;
    logic [31:0] rdata;
  } scp_state_t;

  scp_state_t st_reg;
  scp_state_t st_next;

  logic wr_cfg;
  logic wr_count;
  logic wr_scaled;
  logic [NCMP-1:0] wr_cmp;
  logic count_en;
  logic [CMP_W-1:0] scaled;
  logic [CW-1:0] low_mask;
  logic [CW-1:0] win_mask;
  logic zero_evt;
  logic wrap_evt;
  logic period_end;
  logic [NCMP-1:0] ge;
  logic [NCMP-1:0] pend_nx;
  logic [31:0] cfg_word;

  // Address decode; writes are taken in the cycle REG_WR is high.
  assign wr_cfg = REG_WR && (REG_ADDR == OFS_CFG);
  assign wr_count = REG_WR && (REG_ADDR == OFS_COUNT);
  assign wr_scaled = REG_WR && (REG_ADDR == OFS_SCALED);
  assign wr_cmp[0] = REG_WR && (REG_ADDR == OFS_CMP0);
  assign wr_cmp[1] = REG_WR && (REG_ADDR == OFS_CMP1);
  assign wr_cmp[2] = REG_WR && (REG_ADDR == OFS_CMP2);
  assign wr_cmp[3] = REG_WR && (REG_ADDR == OFS_CMP3);

  // Either enable lets the counter run.
  assign count_en = st_reg.en_always | st_reg.en_oneshot;

  // The window starts at the scale bit; scale 0 is the low bits.
  assign scaled = CMP_W'(st_reg.count >> st_reg.scale);
  assign low_mask = (CW'(1) << st_reg.scale) - CW'(1);
  assign win_mask = CW'({CMP_W{1'b1}}) << st_reg.scale;

  // Period ends on a compare-zero match or on the window carry-out.
  assign zero_evt = st_reg.zero_cmp & ge[0];
  assign wrap_evt = ~st_reg.zero_cmp & count_en & (&scaled)
    & (&(st_reg.count | ~low_mask));
  assign period_end = zero_evt | wrap_evt;

  // All comparators look at the same window every cycle.
  generate
    for (genvar i = 0; i < NCMP; i++)
    begin : g_chan
      scp_compare #(
        .CMP_W(CMP_W)
      ) u_cmp (
        .scaled(scaled),
        .value(st_reg.cmp[i]),
        .center(st_reg.center[i]),
        .ge(ge[i])
      );
      scp_pending u_pend (
        .ge(ge[i]),
        .pend(st_reg.pend[i]),
        .sticky(st_reg.sticky),
        .deglitch(st_reg.deglitch),
        .period_end(period_end),
        .wr(wr_cfg),
        .wbit(REG_WDATA[POS_PEND+i]),
        .pend_next(pend_nx[i])
      );
    end
  endgenerate

  // Configuration word as software sees it; gaps read zero.
  always_comb
  begin
    cfg_word = RST_WORD;
    cfg_word[POS_SCALE +: SCALE_W] = st_reg.scale;
    cfg_word[POS_STICKY] = st_reg.sticky;
    cfg_word[POS_ZERO] = st_reg.zero_cmp;
    cfg_word[POS_DEGLITCH] = st_reg.deglitch;
    cfg_word[POS_EN_ALWAYS] = st_reg.en_always;
    cfg_word[POS_EN_ONESHOT] = st_reg.en_oneshot;
    cfg_word[POS_CENTER +: NCMP] = st_reg.center;
    cfg_word[POS_GANG +: NCMP] = st_reg.gang;
    cfg_word[POS_PEND +: NCMP] = st_reg.pend;
  end

  // Next-state logic for the whole block.
  always_comb
  begin
    st_next = st_reg;

    // Configuration fields; reserved bits are simply not stored.
    if (wr_cfg)
    begin
      st_next.scale = REG_WDATA[POS_SCALE +: SCALE_W];
      st_next.sticky = REG_WDATA[POS_STICKY];
      st_next.zero_cmp = REG_WDATA[POS_ZERO];
      st_next.deglitch = REG_WDATA[POS_DEGLITCH];
      st_next.en_always = REG_WDATA[POS_EN_ALWAYS];
      st_next.center = REG_WDATA[POS_CENTER +: NCMP];
      st_next.gang = REG_WDATA[POS_GANG +: NCMP];
    end

    // A rearm write in the ending cycle wins over the self-clear.
    if (wr_cfg)
    begin
      st_next.en_oneshot = REG_WDATA[POS_EN_ONESHOT];
    end
    else if (period_end)
    begin
      st_next.en_oneshot = 1'b0;
    end

    // Counter: a software write beats the clear, which beats a step.
    if (wr_count)
    begin
      st_next.count = REG_WDATA[CW-1:0];
    end
    else if (wr_scaled)
    begin
      st_next.count = (st_reg.count & ~win_mask)
        | (CW'(REG_WDATA[CMP_W-1:0]) << st_reg.scale);
    end
    else if (zero_evt)
    begin
      st_next.count = RST_WORD[CW-1:0];
    end
    else if (count_en)
    begin
      // Natural wrap is the carry out of the top bit.
      st_next.count = st_reg.count + CW'(1);
    end

    // Compare values keep only the low window-width bits.
    for (int i = 0; i < NCMP; i++)
    begin
      if (wr_cmp[i])
      begin
        st_next.cmp[i] = REG_WDATA[CMP_W-1:0];
      end
    end

    // Pending bits and pins move together, one clock after compare.
    st_next.pend = pend_nx;
    for (int i = 0; i < NCMP; i++)
    begin
      st_next.pin[i] = pend_nx[i]
        & ~(st_next.gang[i] & pend_nx[(i + 1) % NCMP]);
    end

    // Read data is registered; it is held between reads.
    if (REG_RD)
    begin
      case (REG_ADDR)
        OFS_CFG: st_next.rdata = cfg_word;
        OFS_COUNT: st_next.rdata = 32'(st_reg.count);
        OFS_SCALED: st_next.rdata = 32'(scaled);
        OFS_CMP0: st_next.rdata = 32'(st_reg.cmp[0]);
        OFS_CMP1: st_next.rdata = 32'(st_reg.cmp[1]);
        OFS_CMP2: st_next.rdata = 32'(st_reg.cmp[2]);
        OFS_CMP3: st_next.rdata = 32'(st_reg.cmp[3]);
        default: st_next.rdata = RD_UNMAPPED;
      endcase
    end
  end

  // State register; reset leaves the counter stopped.
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops.
  assign REG_RDATA = st_reg.rdata;
  assign COMPARE_PENDING = st_reg.pend;
  assign WAVEFORM_PIN_OUT = st_reg.pin;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  // A running counter steps by exactly one.
  a_count_step: assert property (
    count_en && !zero_evt && !wr_count && !wr_scaled
    |=> st_reg.count == CW'($past(st_reg.count) + 1'b1))
    else $error("counter did not step by one");

  // A stopped counter holds.
  a_count_hold: assert property (
    !count_en && !zero_evt && !wr_count && !wr_scaled
    |=> $stable(st_reg.count))
    else $error("stopped counter moved");

  // Compare-zero match clears the counter on the next edge.
  a_zero_clear: assert property (
    zero_evt && !wr_count && !wr_scaled |=> st_reg.count == '0)
    else $error("counter not cleared after match");

  // One-shot enable drops at period end unless rewritten.
  a_oneshot_drop: assert property (
    period_end && !wr_cfg |=> !st_reg.en_oneshot)
    else $error("one-shot enable survived period end");

  // Scale zero shows the low counter bits.
  a_scale_zero: assert property (
    st_reg.scale == '0 |-> scaled == st_reg.count[CMP_W-1:0])
    else $error("unscaled window mismatch");

  // Plain comparator zero result.
  a_compare_ge: assert property (
    !st_reg.center[0] |-> ge[0] == (scaled >= st_reg.cmp[0]))
    else $error("comparator zero result wrong");

  // A compare result shows in pending one clock later.
  a_pend_set: assert property (
    ge != '0 |=> (st_reg.pend & $past(ge)) == $past(ge))
    else $error("pending missed a compare");

  // Sticky keeps every set pending bit.
  a_sticky_hold: assert property (
    st_reg.sticky |=> (st_reg.pend & $past(st_reg.pend))
    == $past(st_reg.pend))
    else $error("sticky pending bit cleared");

  // Deglitched pending bits hold inside the period.
  a_deglitch_hold: assert property (
    st_reg.deglitch && !period_end && !wr_cfg
    |=> (st_reg.pend & $past(st_reg.pend)) == $past(st_reg.pend))
    else $error("deglitched pending fell mid period");

  // Compare reads return zero above the value field.
  a_cmp_reserved: assert property (
    REG_RD && REG_ADDR == OFS_CMP1 |=> REG_RDATA[31:CMP_W] == '0)
    else $error("reserved compare bits not zero");

  // Pins follow pending through the gang stage.
  a_pin_gang: assert property (
    WAVEFORM_PIN_OUT == (st_reg.pend & ~(st_reg.gang
    & {st_reg.pend[0], st_reg.pend[NCMP-1:1]})))
    else $error("pin does not match gang stage");

  // Enables come on only through a configuration write.
  a_enable_source: assert property (
    !wr_cfg |=> !$rose(st_reg.en_always) && !$rose(st_reg.en_oneshot))
    else $error("counting enable rose without a write");

  // Continuous enable keeps the counter moving.
  a_always_runs: assert property (
    st_reg.en_always && !zero_evt && !wr_count && !wr_scaled
    |=> st_reg.count != $past(st_reg.count))
    else $error("continuous counter stalled");

  // Without zero-on-match the full counter wraps to zero.
  a_wrap_zero: assert property (
    count_en && !st_reg.zero_cmp && (&st_reg.count)
    && !wr_count && !wr_scaled |=> st_reg.count == '0)
    else $error("counter did not wrap to zero");

  // Maximum scale shows the counter bits above the extra width.
  a_scale_top: assert property (
    st_reg.scale == {SCALE_W{1'b1}}
    |-> scaled == st_reg.count[CW-1:COUNT_EXTRA])
    else $error("top scale window mismatch");

  // A window write shows up as the new scaled count.
  a_window_write: assert property (
    wr_scaled |=> scaled == $past(REG_WDATA[CMP_W-1:0]))
    else $error("scaled count write lost");

  // Reads of the scaled view return the window in the low bits.
  a_scaled_read: assert property (
    REG_RD && REG_ADDR == OFS_SCALED |=> REG_RDATA == 32'($past(scaled)))
    else $error("scaled count read wrong");

  // Compare writes keep the low value bits.
  a_cmp_store: assert property (
    wr_cmp[2] |=> st_reg.cmp[2] == $past(REG_WDATA[CMP_W-1:0]))
    else $error("compare value two not stored");

  // Center mode folds the window past its midpoint.
  a_center_fold: assert property (
    st_reg.center[2] && scaled[CMP_W-1]
    |-> ge[2] == (~scaled >= st_reg.cmp[2]))
    else $error("center comparison not folded");

  // One-shot enable lasts until the period ends.
  a_oneshot_keep: assert property (
    st_reg.en_oneshot && !period_end && !wr_cfg |=> st_reg.en_oneshot)
    else $error("one-shot enable dropped early");

  // A configuration write clears a pending bit not held otherwise.
  a_pend_clear: assert property (
    wr_cfg && !st_reg.sticky && !REG_WDATA[POS_PEND] && !ge[0]
    |=> !st_reg.pend[0])
    else $error("pending bit not cleared by write");

  // Reserved configuration bits read as zero.
  a_cfg_reserved: assert property (
    REG_RD && REG_ADDR == OFS_CFG |=> (REG_RDATA & 32'h00F0_C8F0) == '0)
    else $error("reserved configuration bits not zero");

endmodule

// File: test/scp_host_model.sv
`timescale 1ns/1ps
// Processor-side bus master; it drives 1 ns after each rising edge.
module scp_host_model
(
  // Clock.
  input wire logic clk,
  // Register port.
  output logic [5:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata
);
  // Idle bus at time zero.
  initial
  begin
    reg_addr = 6'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0000_0000;
  end

  // One-cycle write strobe.
  // The next call waits an edge, so strobes never merge.
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask

  // Read data is registered at the strobe edge, so it is taken just after.
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask
endmodule

// File: test/scp_core_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end \
  end
module scp_core_tb_top
  import scp_pkg::*;
;
  logic ref_clk;
  logic rstn;
  logic [5:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [3:0] pend;
  logic [3:0] pins;
  logic [31:0] d;
  logic [31:0] d1;
  logic [31:0] mx;
  int failures;
  int total_checks;
  logic [31:0] vals [5] = '{32'h4567_89AB, 32'h4567_89AB, 32'h4567_89AB,
    32'h0000_7FFF, 32'h0000_8000};
  logic [31:0] scl [5] = '{32'h0, 32'h4, 32'hF, 32'hF, 32'hF};
  logic [31:0] cv [4] = '{32'h4, 32'h5, 32'h7FFE, 32'h0};

  // Free-running 200 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  scp_host_model i_host (.clk(ref_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  scp_core i_dut (.REF_CLK(ref_clk), .RSTN(rstn), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .COMPARE_PENDING(pend),
    .WAVEFORM_PIN_OUT(pins));

  // Verdict and end of run.
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Registered outputs need a few edges after a write.
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // Polls until the one-shot enable drops; the bound catches a hang.
  task automatic shot_wait();
    mx = 32'h0;
    for (int n = 0; n <= 40; n++)
    begin
      if (n == 40)
      begin
        failures++;
        conclude();
      end
      i_host.rd(OFS_COUNT, d);
      if (d > mx)
        mx = d;
      i_host.rd(OFS_CFG, d);
      if (d[POS_EN_ONESHOT] === 1'b0)
        break;
    end
  endtask

  // Main sequence.
  initial
  begin
    failures = 0;
    total_checks = 0;
    rstn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    i_host.rd(OFS_CFG, d);
    `CHK("cfg", 32'hF000_0000, d)
    i_host.rd(OFS_COUNT, d);
    `CHK("count", 32'h0, d)
    i_host.rd(6'h04, d);
    `CHK("unmapped", RD_UNMAPPED, d)
    for (int i = 0; i < 4; i++)
    begin
      i_host.wr(OFS_CMP0 + 6'(4 * i), 32'hFFFF_1230 + i);
      i_host.rd(OFS_CMP0 + 6'(4 * i), d);
      `CHK("cmp", 32'h1230 + i, d)
    end
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      i_host.wr(OFS_COUNT, vals[i]);
      i_host.wr(OFS_CFG, scl[i]);
      i_host.rd(OFS_SCALED, d);
      `CHK("scaled", 16'(vals[i] >> scl[i]), d)
    end
    $display("test scale done");
    i_host.wr(OFS_COUNT, 32'h7FFF_FFFC);
    i_host.wr(OFS_CFG, 32'h0000_1000);
    i_host.rd(OFS_COUNT, d1);
    i_host.rd(OFS_COUNT, d);
    `CHK("step", (d1 + 32'h2) & 32'h7FFF_FFFF, d)
    i_host.rd(OFS_COUNT, d);
    `CHK("wrap", 1'b1, d < 32'h10)
    $display("test run done");
    i_host.wr(OFS_CFG, 32'h0);
    i_host.wr(OFS_COUNT, 32'h0);
    i_host.wr(OFS_CMP0, 32'h9);
    i_host.wr(OFS_CFG, 32'h0000_2200);
    shot_wait();
    `CHK("period", 1'b1, mx <= 32'h9)
    i_host.rd(OFS_COUNT, d);
    `CHK("stopped", 32'h0, d)
    i_host.wr(OFS_CFG, 32'h0000_2200);
    i_host.rd(OFS_CFG, d);
    `CHK("rearm", 1'b1, d[POS_EN_ONESHOT])
    shot_wait();
    `CHK("replay", 1'b1, mx <= 32'h9)
    $display("test oneshot done");
    i_host.wr(OFS_CFG, 32'h0);
    i_host.wr(OFS_COUNT, 32'h5);
    for (int i = 0; i < 4; i++)
      i_host.wr(OFS_CMP0 + 6'(4 * i), cv[i]);
    settle();
    `CHK("pend", 4'b1011, pend)
    `CHK("pins", 4'b1011, pins)
    i_host.wr(OFS_CFG, 32'h0000_0100);
    i_host.wr(OFS_CMP3, 32'h7);
    i_host.wr(OFS_CFG, 32'h0000_0100);
    settle();
    `CHK("sticky", 4'b1011, pend)
    i_host.wr(OFS_CFG, 32'h0);
    settle();
    `CHK("clear", 4'b0011, pend)
    i_host.wr(OFS_CFG, 32'h0100_0000);
    settle();
    `CHK("gang", 4'b0010, pins)
    i_host.wr(OFS_COUNT, 32'h0001_8002);
    i_host.wr(OFS_CFG, 32'h0004_0000);
    settle();
    `CHK("center", 4'b1011, pend)
    i_host.wr(OFS_CFG, 32'h0);
    settle();
    `CHK("plain", 4'b1111, pend)
    // Deglitch keeps pending bits whose compare has fallen mid period.
    i_host.wr(OFS_CFG, 32'h0000_0400);
    i_host.wr(OFS_CMP3, 32'hFFFF);
    settle();
    `CHK("deglitch", 4'b1111, pend)
    i_host.wr(OFS_SCALED, 32'h0000_0002);
    i_host.rd(OFS_COUNT, d);
    `CHK("window", 32'h0001_0002, d)
    settle();
    `CHK("latched", 4'b1111, pend)
    i_host.wr(OFS_CFG, 32'h0000_0400);
    settle();
    `CHK("cleared", 4'b0000, pend)
    $display("test compare done");
    // A reset in mid-run must stop a running counter again.
    i_host.wr(OFS_CFG, 32'h0000_3000);
    rstn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    i_host.rd(OFS_CFG, d);
    `CHK("rst_cfg", 32'hF000_0000, d)
    i_host.rd(OFS_COUNT, d);
    `CHK("rst_count", 32'h0, d)
    $display("test reset done");
    conclude();
  end
endmodule
